// *** include/pic_consts.svh ***
// Offsets, field positions, event positions and reset values
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// Register offsets
`define PIC_OFS_EVT_LOW     8'h08
`define PIC_OFS_EVT_HIGH    8'h09
`define PIC_OFS_MASK_LOW    8'h0c
`define PIC_OFS_MASK_HIGH   8'h0d
`define PIC_OFS_DOMAIN_CTRL 8'h0e
`define PIC_OFS_START_CTRL  8'h0f

// Power domain control fields
`define PIC_BIT_LOCK_SEC    6
`define PIC_BIT_LOCK_MAIN   5
`define PIC_BIT_LOCK_SYS    4
`define PIC_BIT_STANDBY     3
`define PIC_BIT_TGT_SEC     2
`define PIC_BIT_TGT_MAIN    1
`define PIC_BIT_TGT_SYS     0

// Start-up option fields
`define PIC_BIT_SOFT_START  7
`define PIC_BIT_KEY_LOCK    4
`define PIC_BIT_RST_MODE    3
`define PIC_BIT_FLASH       2
`define PIC_BIT_WDT_PD      1
`define PIC_BIT_CHARGER_SOURCE_SELECT     0

// Shared event positions and reset event limit
`define PIC_BIT_TWO_WIRE    14
`define PIC_BIT_PORT_BASE   8
`define PIC_RST_EVT_LIMIT   2'h3

// Reset values
`define PIC_RST_MASK_LOW    8'hff
`define PIC_RST_MASK_HIGH   8'hff
`define PIC_RST_DOMAIN_CTRL 8'h00
`define PIC_RST_START_CTRL  8'h00

`endif

// *** include/pic_pkg.sv ***
// Types shared by the power and interrupt control registers
package pic_pkg;

  // Complete state of the register block
  typedef struct packed {
    logic [7:0]  maskLow;
    logic [7:0]  maskHigh;
    logic [7:0]  domainCtrl;
    logic [7:0]  startCtrl;
    logic [15:0] evtFlags;
    logic [15:0] inPrev;
    logic [2:0]  portPrev;
    logic        irqN;
    logic        rstOutN;
    logic [7:0]  rdData;
    logic        pdStart;
    logic        partialHold;
    logic        flashEn;
    logic        wdtRun;
    logic        halfCurrent;
  } pic_state_s;

endpackage

// *** design/pic_ctrl_regs.sv ***
// Interrupt mask and power control register bank
`include "pic_consts.svh"

module pic_ctrl_regs
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port from the serial control interface
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // Event sources
  input  wire logic [15:0] general_input,
  input  wire logic [15:0] inputActiveHigh,
  input  wire logic [2:0]  analogThreshEvt,
  input  wire logic        fast_two_wire_port,
  // Domain enable ports and stored defaults
  input  wire logic        sys_domain_port,
  input  wire logic        main_domain_port,
  input  wire logic        secondary_domain_port,
  input  wire logic        loadDefaults,
  input  wire logic [2:0]  defaultTargets,
  // Sequencer and system status
  input  wire logic        powerUpSeq,
  input  wire logic        leaveLowPower,
  input  wire logic        low_power_state,
  input  wire logic [1:0]  resetEventSel,
  input  wire logic        startupSupplyOk,
  input  wire logic        extSupplyPresent,
  // Outputs
  output logic             irq_out_n,
  output logic             system_reset_out_n,
  output logic [2:0]       domainTargets,
  output logic             powerDownStart,
  output logic             partial_down_pointer,
  output logic             converter_soft_start,
  output logic             key_wake_lock,
  output logic             halfCurrentPd,
  output logic             limited_flash_enable,
  output logic             wdt_run_in_low_power_state,
  output logic             charger_source_select
);

  pic_state_s st_reg;
  pic_state_s st_next;

  logic [2:0]  portNow;
  logic [15:0] gpiHit;
  logic [15:0] evtSet;
  logic [15:0] evtClr;
  logic        wrDom;
  logic        wrStart;

  assign portNow = {secondary_domain_port, main_domain_port,
                    sys_domain_port};

  // Per input detection of entry into the active state
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_in
      assign gpiHit[gi] =
        (general_input[gi] == inputActiveHigh[gi]) &&
        (st_reg.inPrev[gi] != inputActiveHigh[gi]);
    end
  endgenerate

  assign wrDom   = regWrEn && (regAddr == `PIC_OFS_DOMAIN_CTRL);
  assign wrStart = regWrEn && (regAddr == `PIC_OFS_START_CTRL);

  // Event sources merged onto shared flag positions
  always_comb begin
    evtSet = gpiHit;
    evtSet[2:0] = evtSet[2:0] | analogThreshEvt;
    evtSet[`PIC_BIT_TWO_WIRE] = evtSet[`PIC_BIT_TWO_WIRE] |
                                fast_two_wire_port;
    evtSet[`PIC_BIT_PORT_BASE +: 3] = evtSet[`PIC_BIT_PORT_BASE +: 3] |
                                      (portNow ^ st_reg.portPrev);
    evtClr = 16'h0000;
    if (regWrEn && regAddr == `PIC_OFS_EVT_LOW) begin
      evtClr[7:0] = regWrData;
    end
    if (regWrEn && regAddr == `PIC_OFS_EVT_HIGH) begin
      evtClr[15:8] = regWrData;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.inPrev   = general_input;
    st_next.portPrev = portNow;
    st_next.pdStart  = 1'b0;
    // a new event beats the clear
    st_next.evtFlags = (st_reg.evtFlags & ~evtClr) | evtSet;
    if (regWrEn && regAddr == `PIC_OFS_MASK_LOW) begin
      st_next.maskLow = regWrData;
    end
    if (regWrEn && regAddr == `PIC_OFS_MASK_HIGH) begin
      st_next.maskHigh = regWrData;
    end
    if (wrStart) begin
      st_next.startCtrl = regWrData;
    end else if (powerUpSeq) begin
      st_next.startCtrl[`PIC_BIT_KEY_LOCK] = 1'b0;
    end
    if (wrDom) begin
      st_next.domainCtrl[7:3] = regWrData[7:3];
      if (!st_reg.domainCtrl[`PIC_BIT_LOCK_SEC]) begin
        st_next.domainCtrl[`PIC_BIT_TGT_SEC] = regWrData[`PIC_BIT_TGT_SEC];
      end
      if (!st_reg.domainCtrl[`PIC_BIT_LOCK_MAIN]) begin
        st_next.domainCtrl[`PIC_BIT_TGT_MAIN] =
          regWrData[`PIC_BIT_TGT_MAIN];
      end
      if (!st_reg.domainCtrl[`PIC_BIT_LOCK_SYS]) begin
        st_next.domainCtrl[`PIC_BIT_TGT_SYS] = regWrData[`PIC_BIT_TGT_SYS];
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (portNow[k] != st_reg.portPrev[k]) begin
        st_next.domainCtrl[k] = portNow[k];
      end
    end
    if (loadDefaults) begin
      st_next.domainCtrl[2:0] = defaultTargets;
    end
    if (st_reg.domainCtrl[`PIC_BIT_TGT_SYS] &&
        !st_next.domainCtrl[`PIC_BIT_TGT_SYS]) begin
      st_next.pdStart     = 1'b1;
      st_next.partialHold = st_reg.domainCtrl[`PIC_BIT_STANDBY];
      if (st_reg.startCtrl[`PIC_BIT_RST_MODE]) begin
        st_next.rstOutN = 1'b0;
      end
    end
    if (leaveLowPower && !st_reg.rstOutN &&
        resetEventSel < `PIC_RST_EVT_LIMIT) begin
      st_next.rstOutN = 1'b1;
    end
    st_next.flashEn = st_reg.startCtrl[`PIC_BIT_FLASH] &&
                      startupSupplyOk && !extSupplyPresent;
    st_next.wdtRun = !low_power_state ||
                     st_reg.startCtrl[`PIC_BIT_WDT_PD];
    st_next.irqN = ~|(st_next.evtFlags &
                      ~{st_next.maskHigh, st_next.maskLow});
    st_next.halfCurrent = !st_next.startCtrl[`PIC_BIT_KEY_LOCK];
    // Read data path, unmapped reads zero
    if (regRdEn) begin
      case (regAddr)
        `PIC_OFS_EVT_LOW:     st_next.rdData = st_reg.evtFlags[7:0];
        `PIC_OFS_EVT_HIGH:    st_next.rdData = st_reg.evtFlags[15:8];
        `PIC_OFS_MASK_LOW:    st_next.rdData = st_reg.maskLow;
        `PIC_OFS_MASK_HIGH:   st_next.rdData = st_reg.maskHigh;
        `PIC_OFS_DOMAIN_CTRL: st_next.rdData = st_reg.domainCtrl;
        `PIC_OFS_START_CTRL:  st_next.rdData = st_reg.startCtrl;
        default:              st_next.rdData = 8'h00;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.maskLow     <= `PIC_RST_MASK_LOW;
      st_reg.maskHigh    <= `PIC_RST_MASK_HIGH;
      st_reg.domainCtrl  <= `PIC_RST_DOMAIN_CTRL;
      st_reg.startCtrl   <= `PIC_RST_START_CTRL;
      st_reg.irqN        <= 1'b1;
      st_reg.rstOutN     <= 1'b1;
      st_reg.wdtRun      <= 1'b1;
      st_reg.halfCurrent <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign regRdData             = st_reg.rdData;
  assign irq_out_n             = st_reg.irqN;
  assign system_reset_out_n    = st_reg.rstOutN;
  assign domainTargets         = st_reg.domainCtrl[2:0];
  assign powerDownStart        = st_reg.pdStart;
  assign partial_down_pointer  = st_reg.partialHold;
  assign converter_soft_start  = st_reg.startCtrl[`PIC_BIT_SOFT_START];
  assign key_wake_lock         = st_reg.startCtrl[`PIC_BIT_KEY_LOCK];
  assign halfCurrentPd         = st_reg.halfCurrent;
  assign limited_flash_enable  = st_reg.flashEn;
  assign wdt_run_in_low_power_state  = st_reg.wdtRun;
  assign charger_source_select = st_reg.startCtrl[`PIC_BIT_CHARGER_SOURCE_SELECT];

  // Checks on the block's own behaviour
  sequence s_wrLockedSec;
    wrDom && st_reg.domainCtrl[`PIC_BIT_LOCK_SEC] && !loadDefaults &&
    secondary_domain_port == st_reg.portPrev[2];
  endsequence

  sequence s_sysDrop;
    st_reg.domainCtrl[`PIC_BIT_TGT_SYS] &&
    !st_next.domainCtrl[`PIC_BIT_TGT_SYS];
  endsequence

  property p_irqMatch;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> irq_out_n ==
      !(|(st_reg.evtFlags & ~{st_reg.maskHigh, st_reg.maskLow}));
  endproperty
  a_irqMatch: assert property (p_irqMatch)
    else $error("interrupt level disagrees with masked flags");

  property p_threshMasked;
    @(posedge clk) disable iff (!rst_n)
      (analogThreshEvt[0] && st_reg.maskLow[0] &&
       st_reg.evtFlags[15:1] == 15'h0000 && evtSet[15:1] == 15'h0000 &&
       !regWrEn) |=> irq_out_n;
  endproperty
  a_threshMasked: assert property (p_threshMasked)
    else $error("masked threshold event drove interrupt");

  property p_twoWire;
    @(posedge clk) disable iff (!rst_n)
      (fast_two_wire_port && !st_reg.maskHigh[6] && !regWrEn) |=> !irq_out_n;
  endproperty
  a_twoWire: assert property (p_twoWire)
    else $error("two-wire event did not assert interrupt");

  property p_lockSec;
    @(posedge clk) disable iff (!rst_n)
      s_wrLockedSec |=> domainTargets[2] == $past(st_reg.domainCtrl[2]);
  endproperty
  a_lockSec: assert property (p_lockSec)
    else $error("locked secondary target changed on write");

  property p_standby;
    @(posedge clk) disable iff (!rst_n)
      s_sysDrop |=> powerDownStart &&
      partial_down_pointer == $past(st_reg.domainCtrl[3]);
  endproperty
  a_standby: assert property (p_standby)
    else $error("power-down outcome does not follow standby bit");

  property p_keyClear;
    @(posedge clk) disable iff (!rst_n)
      (powerUpSeq && !wrStart) |=> !key_wake_lock && halfCurrentPd;
  endproperty
  a_keyClear: assert property (p_keyClear)
    else $error("key wake lock not cleared at power-up");

  property p_resetOut;
    @(posedge clk) disable iff (!rst_n)
      (s_sysDrop and st_reg.startCtrl[3]) |=> !system_reset_out_n;
  endproperty
  a_resetOut: assert property (p_resetOut)
    else $error("reset not asserted before power-down");

  property p_wdt;
    @(posedge clk) disable iff (!rst_n)
      (low_power_state && !st_reg.startCtrl[1]) |=> !wdt_run_in_low_power_state;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog kept running in power-down");

  property p_holdFlag;
    @(posedge clk) disable iff (!rst_n)
      (st_reg.evtFlags[5] &&
       !(regWrEn && regAddr == `PIC_OFS_EVT_LOW && regWrData[5]))
      |=> st_reg.evtFlags[5] [*1];
  endproperty
  a_holdFlag: assert property (p_holdFlag)
    else $error("event flag dropped without write-back");

  property p_maskedSets;
    @(posedge clk) disable iff (!rst_n)
      (gpiHit[3] && st_reg.maskLow[3]) |=> st_reg.evtFlags[3];
  endproperty
  a_maskedSets: assert property (p_maskedSets)
    else $error("masked input event did not set its flag");

  property p_inputEvt;
    @(posedge clk) disable iff (!rst_n)
      (general_input[9] == inputActiveHigh[9] &&
       st_reg.inPrev[9] != inputActiveHigh[9]) |=> st_reg.evtFlags[9];
  endproperty
  a_inputEvt: assert property (p_inputEvt)
    else $error("input reaching active state set no flag");

  property p_maskWrite;
    @(posedge clk) disable iff (!rst_n)
      (regWrEn && regAddr == `PIC_OFS_MASK_LOW) |=>
      st_reg.maskLow == $past(regWrData);
  endproperty
  a_maskWrite: assert property (p_maskWrite)
    else $error("low mask write did not land");

  property p_softStart;
    @(posedge clk) disable iff (!rst_n)
      wrStart |=> converter_soft_start == $past(regWrData[7]);
  endproperty
  a_softStart: assert property (p_softStart)
    else $error("soft-start output does not follow its bit");

  property p_charger;
    @(posedge clk) disable iff (!rst_n)
      wrStart |=> charger_source_select == $past(regWrData[0]);
  endproperty
  a_charger: assert property (p_charger)
    else $error("charger source output does not follow its bit");

  property p_flash;
    @(posedge clk) disable iff (!rst_n)
      (st_reg.startCtrl[`PIC_BIT_FLASH] && startupSupplyOk &&
       !extSupplyPresent) |=> limited_flash_enable;
  endproperty
  a_flash: assert property (p_flash)
    else $error("limited flashing not enabled without supply");

  property p_portTarget;
    @(posedge clk) disable iff (!rst_n)
      (main_domain_port != st_reg.portPrev[1] && !loadDefaults) |=>
      domainTargets[1] == $past(main_domain_port);
  endproperty
  a_portTarget: assert property (p_portTarget)
    else $error("main target did not follow its port");

  property p_portEvt;
    @(posedge clk) disable iff (!rst_n)
      (main_domain_port != st_reg.portPrev[1] && !st_reg.maskHigh[1] &&
       !regWrEn) |=> !irq_out_n;
  endproperty
  a_portEvt: assert property (p_portEvt)
    else $error("unmasked port event did not assert interrupt");

endmodule

// *** tb/pic_host_model.sv ***
// Host model that drives the register port of the control block
module pic_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn   <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn   <= 1'b0;
    regAddr   <= ~a; // Released lines show no stale value
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    @(posedge clk);
    d = regRdData;
  endtask
endmodule

// *** tb/pic_ctrl_regs_bench.sv ***
// Self-checking bench of the interrupt mask and power control registers
`include "pic_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end

module pic_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, regWrEn, regRdEn, fast_two_wire_port;
  logic [7:0]  regAddr, regWrData, regRdData, rv, v;
  logic [15:0] general_input, inputActiveHigh;
  logic [2:0]  analogThreshEvt, defaultTargets, domainTargets;
  logic        sys_domain_port, main_domain_port, secondary_domain_port;
  logic        loadDefaults, powerUpSeq, leaveLowPower, low_power_state;
  logic [1:0]  resetEventSel;
  logic        startupSupplyOk, extSupplyPresent, irq_out_n;
  logic        system_reset_out_n, powerDownStart, partial_down_pointer;
  logic        converter_soft_start, key_wake_lock, halfCurrentPd;
  logic        limited_flash_enable, wdt_run_in_low_power_state;
  logic        charger_source_select;
  int          err_total, checked, cycles, pdCnt;

  pic_ctrl_regs dut (.clk, .rst_n, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .general_input, .inputActiveHigh,
    .analogThreshEvt, .fast_two_wire_port, .sys_domain_port,
    .main_domain_port, .secondary_domain_port, .loadDefaults,
    .defaultTargets, .powerUpSeq, .leaveLowPower, .low_power_state,
    .resetEventSel, .startupSupplyOk, .extSupplyPresent, .irq_out_n,
    .system_reset_out_n, .domainTargets, .powerDownStart,
    .partial_down_pointer, .converter_soft_start, .key_wake_lock,
    .halfCurrentPd, .limited_flash_enable, .wdt_run_in_low_power_state,
    .charger_source_select);
  pic_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData,
    .regRdData);

  // Clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard and power-down pulse counter
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  always @(negedge clk) if (powerDownStart === 1'b1) pdCnt++;

  // Flag position of an event source within its byte
  function automatic logic [7:0] evtBit(input int i);
    return 8'h01 << (i % 8);
  endfunction
  // Wait edges, then let outputs settle
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Read one register and compare
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    `CHK(rv, e)
  endtask
  // Raise one event under a chosen mask, then clear it by write-back
  task automatic evt(input int k, input int i, input logic m);
    logic [15:0] msk;
    logic [7:0]  ofs;
    msk = 16'hffff;
    msk[i] = m;
    ofs = (i < 8) ? `PIC_OFS_EVT_LOW : `PIC_OFS_EVT_HIGH;
    host.wr(`PIC_OFS_MASK_LOW, msk[7:0]);
    host.wr(`PIC_OFS_MASK_HIGH, msk[15:8]);
    @(posedge clk);
    case (k)
      0: general_input[i] <= inputActiveHigh[i];
      1: analogThreshEvt[i] <= 1'b1;
      default: fast_two_wire_port <= 1'b1;
    endcase
    @(posedge clk);
    analogThreshEvt <= 3'h0;
    fast_two_wire_port <= 1'b0;
    host.rd(ofs, rv);
    `CHK(rv, evtBit(i))
    `CHK(irq_out_n, m)
    host.wr(ofs, rv);
    general_input[i] <= ~inputActiveHigh[i];
    settle(2);
    `CHK(irq_out_n, 1'b1)
    rdChk(ofs, 8'h00);
  endtask
  task automatic stop_test();
    $display("Counts: checked %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h8865ed83));
    inputActiveHigh = $urandom;
    general_input = ~inputActiveHigh;
    {rst_n, analogThreshEvt, fast_two_wire_port, loadDefaults} = '0;
    {sys_domain_port, main_domain_port, secondary_domain_port} = '0;
    {defaultTargets, powerUpSeq, leaveLowPower, low_power_state} = '0;
    {resetEventSel, startupSupplyOk, extSupplyPresent} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped offset
    rdChk(`PIC_OFS_MASK_LOW, `PIC_RST_MASK_LOW);
    rdChk(`PIC_OFS_MASK_HIGH, `PIC_RST_MASK_HIGH);
    rdChk(`PIC_OFS_DOMAIN_CTRL, `PIC_RST_DOMAIN_CTRL);
    rdChk(8'h20, 8'h00);
    rdChk(`PIC_OFS_START_CTRL, `PIC_RST_START_CTRL);
    `CHK(irq_out_n, 1'b1)
    `CHK(system_reset_out_n, 1'b1)
    $display("Reset test done");
    repeat (12) evt(0, $urandom % 16, $urandom % 2);
    for (int i = 0; i < 3; i++) evt(1, i, $urandom % 2);
    evt(2, `PIC_BIT_TWO_WIRE, 1'b0);
    evt(2, `PIC_BIT_TWO_WIRE, 1'b1);
    evt(1, 0, 1'b1);
    evt(0, 3, 1'b1);
    evt(0, 5, 1'b0);
    evt(0, 9, 1'b1);
    $display("Event test done");
    // Random start-up options with random status levels
    repeat (8) begin
      v = $urandom;
      @(posedge clk);
      low_power_state <= $urandom;
      startupSupplyOk <= $urandom;
      extSupplyPresent <= $urandom;
      host.wr(`PIC_OFS_START_CTRL, v);
      settle(2);
      `CHK(converter_soft_start, v[7])
      `CHK(key_wake_lock, v[4])
      `CHK(halfCurrentPd, ~v[4])
      `CHK(limited_flash_enable,
           v[2] & startupSupplyOk & ~extSupplyPresent)
      `CHK(wdt_run_in_low_power_state, ~low_power_state | v[1])
      `CHK(charger_source_select, v[0])
      rdChk(`PIC_OFS_START_CTRL, v);
    end
    host.wr(`PIC_OFS_START_CTRL, 8'h10);
    @(posedge clk);
    powerUpSeq <= 1'b1;
    @(posedge clk);
    powerUpSeq <= 1'b0;
    settle(2);
    `CHK(key_wake_lock, 1'b0)
    `CHK(halfCurrentPd, 1'b1)
    $display("Option test done");
    // Locked writes, standby power-down with reset output
    host.wr(`PIC_OFS_START_CTRL, 8'h08);
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h70);
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h77);
    rdChk(`PIC_OFS_DOMAIN_CTRL, 8'h70);
    `CHK(domainTargets, 3'h0)
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h0f);
    rdChk(`PIC_OFS_DOMAIN_CTRL, 8'h08);
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h0f);
    settle(1);
    `CHK(domainTargets, 3'h7)
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h08);
    settle(2);
    `CHK(pdCnt, 1)
    `CHK(partial_down_pointer, 1'b1)
    `CHK(system_reset_out_n, 1'b0)
    for (int s = 3; s >= 2; s--) begin
      @(posedge clk);
      resetEventSel <= s;
      leaveLowPower <= 1'b1;
      @(posedge clk);
      leaveLowPower <= 1'b0;
      settle(2);
      `CHK(system_reset_out_n, s != 3)
    end
    // Hibernate power-down without reset output
    host.wr(`PIC_OFS_START_CTRL, 8'h00);
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h01);
    host.wr(`PIC_OFS_DOMAIN_CTRL, 8'h00);
    settle(2);
    `CHK(pdCnt, 2)
    `CHK(partial_down_pointer, 1'b0)
    `CHK(system_reset_out_n, 1'b1)
    // Port edge sets its target and raises an unmasked event
    host.wr(`PIC_OFS_MASK_HIGH, 8'h00);
    @(posedge clk);
    main_domain_port <= 1'b1;
    settle(3);
    `CHK(domainTargets, 3'h2)
    `CHK(irq_out_n, 1'b0)
    rdChk(`PIC_OFS_EVT_HIGH, 8'h02);
    @(posedge clk);
    defaultTargets <= 3'h5;
    loadDefaults <= 1'b1;
    @(posedge clk);
    loadDefaults <= 1'b0;
    settle(2);
    `CHK(domainTargets, 3'h5)
    $display("Domain test done");
    stop_test();
  end
endmodule
